// ### rtl/pcd_cache.sv
// primary cache: direct mapped, read allocate, write through
//
// Overview of operation
// RULE1 - cache only memory space cpu reads
// RULE2 - allocate only instruction and demand data reads
// RULE3 - uncached or missing reference: one bus reference
// RULE4 - valid hit answered locally, no bus reference
// RULE5 - two kilobytes, direct mapped, quadword blocks
// RULE6 - read allocate only; writes always reach memory
// RULE7 - 256 tags: 18-bit tag, valid, parity
// RULE8 - block holds 8 bytes plus 8 parity
// RULE9 - 64 rows of four blocks and tags
// RULE10 - tag is bits 28:11 with odd parity
// RULE11 - data parity stored only, never checked here
// RULE12 - flush and disable both supported
// RULE13 - bit 2 longword, 8:3 row, 10:9 column
// RULE14 - miss fill forwarded to cpu and stored
// RULE15 - dma write hit invalidates the block
// RULE16 - write hit updates cache and memory
// RULE17 - reset clears every valid bit
`timescale 1ns/1ns
`default_nettype none
module pcd_cache import pcd_pkg::*; (
  input wire logic clk,
  input wire logic reset,
  // cpu side
  input wire logic cpuReqValid,
  output logic cpuReqReady,
  input wire pcd_ref_type cpuReq,
  output logic cpuRspValid,
  output pcd_rsp_type cpuRsp,
  // control from the trap handler
  input wire logic cacheEnable,
  input wire logic flushReq,
  // dma write snoop
  input wire logic dmaWrValid,
  input wire pcd_addr_type dmaWrAddr,
  // cpu memory bus
  output logic memReqValid,
  input wire logic memReqReady,
  output pcd_ref_type memReq,
  output logic memRspReady,
  input wire logic memRspValid,
  input wire pcd_block_type memRsp
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  pcd_ctl_type r_reg;
  pcd_ctl_type r_next;

  logic lookupHit;
  pcd_block_type lookupBlock;
  logic snoopHit;
  logic fillEn;
  pcd_addr_type fillAddr;
  pcd_block_type fillBlock;
  pcd_block_type mergedBlock;
  logic sameBlockDma;

  // ----------------------------------------------------------------
  // geometry checks
  // ----------------------------------------------------------------
  // the package constants must describe one 2 KB direct mapped array
  if (PCD_NUM_BLOCKS * PCD_BYTES != 2048) begin : g_bad_capacity
    $error("pcd_cache: capacity must be 2048 bytes"); // RULE5
  end

  if (PCD_NUM_BLOCKS != 256 || PCD_TAG_W != 18) begin : g_bad_tags
    $error("pcd_cache: 256 tags of 18 bits are required"); // RULE7
  end

  if (PCD_BYTES != 8 || PCD_DATA_W != 8 * PCD_BYTES) begin : g_bad_block
    $error("pcd_cache: a block is 8 bytes with one parity bit each"); // RULE8
  end

  if (PCD_NUM_ROWS != 64 || PCD_NUM_COLS != 4) begin : g_bad_rows
    $error("pcd_cache: 64 rows of 4 blocks are required"); // RULE9
  end

  if (PCD_TAG_HI != 28 || PCD_TAG_LO != 11) begin : g_bad_tag_field
    $error("pcd_cache: the tag field is address bits 28 to 11"); // RULE10
  end

  if (PCD_TAG_LO != PCD_COL_HI + 1 || PCD_COL_LO != PCD_ROW_HI + 1) begin : g_bad_split
    $error("pcd_cache: tag, column and row fields must abut"); // RULE13
  end

  if (PCD_ROW_LO != PCD_LW_BIT + 1) begin : g_bad_lword_bit
    $error("pcd_cache: the longword bit sits just below the row field"); // RULE13
  end

  if (2 * PCD_LWORD_W != PCD_DATA_W) begin : g_bad_lword_width
    $error("pcd_cache: a quadword holds two longwords"); // RULE13
  end

  if (PCD_IO_BIT != PCD_TAG_HI + 1 || PCD_IO_BIT != PCD_PA_HI) begin : g_bad_io_bit
    $error("pcd_cache: the i/o space bit is the top address bit"); // RULE1
  end

  // ----------------------------------------------------------------
  // arrays
  // ----------------------------------------------------------------
  pcd_tag_store #(
    .ROWS(PCD_NUM_ROWS),
    .COLS(PCD_NUM_COLS)
  ) u_store (
    .clk(clk),
    .reset(reset),
    .lookupAddr(r_reg.req.addr),
    .lookupHit(lookupHit),
    .lookupBlock(lookupBlock),
    .snoopAddr(dmaWrAddr),
    .snoopHit(snoopHit),
    .fillEn(fillEn),
    .fillAddr(fillAddr),
    .fillBlock(fillBlock),
    .invEn(dmaWrValid && snoopHit), // RULE15
    .invAddr(dmaWrAddr),
    .flushEn(flushReq) // RULE12
  );

  // ----------------------------------------------------------------
  // write merge, per byte
  // ----------------------------------------------------------------
  // parity travels with its byte untouched; checking is left to the bus interface unit
  for (genvar b = 0; b < PCD_BYTES; b++) begin : g_merge
    assign mergedBlock.data[b*8 +: 8] = r_reg.req.mask[b] ? r_reg.req.wr.data[b*8 +: 8] : lookupBlock.data[b*8 +: 8];
    assign mergedBlock.par[b] = r_reg.req.mask[b] ? r_reg.req.wr.par[b] : lookupBlock.par[b]; // RULE11
  end

  // a dma write to the block being fetched makes the returning data suspect
  assign sameBlockDma = dmaWrValid && dmaWrAddr[PCD_PA_HI:PCD_ROW_LO] == r_reg.req.addr[PCD_PA_HI:PCD_ROW_LO];

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    r_next = r_reg;
    r_next.rspValid = 1'b0;
    fillEn = 1'b0;
    fillAddr = r_reg.req.addr;
    fillBlock = mergedBlock;
    unique case (r_reg.state)
      PCD_ST_IDLE: begin
        if (cpuReqValid) begin
          r_next.req = cpuReq;
          r_next.killFill = 1'b0;
          r_next.state = PCD_ST_CHECK;
        end
      end
      PCD_ST_CHECK: begin
        if (r_reg.req.kind == PCD_WRITE) begin
          // cache copy follows the write even while disabled, so a later enable sees no stale data
          if (lookupHit) begin
            fillEn = 1'b1; // RULE16
          end
          r_next.state = PCD_ST_BUS; // RULE6
        end else if (cacheEnable && pcd_cacheable(r_reg.req.kind, r_reg.req.addr) && lookupHit) begin
          r_next.rsp.rd = lookupBlock; // RULE4
          r_next.rsp.lword = r_reg.req.addr[PCD_LW_BIT] ? lookupBlock.data[PCD_DATA_W-1:PCD_LWORD_W]
                                                        : lookupBlock.data[PCD_LWORD_W-1:0]; // RULE13
          r_next.rsp.fromCache = 1'b1;
          r_next.rspValid = 1'b1;
          r_next.state = PCD_ST_IDLE;
        end else begin
          r_next.state = PCD_ST_BUS; // RULE3
        end
      end
      PCD_ST_BUS: begin
        if (memReqReady) begin
          if (r_reg.req.kind == PCD_WRITE) begin
            r_next.rsp = '0;
            r_next.rsp.rd = r_reg.req.wr;
            r_next.rspValid = 1'b1;
            r_next.state = PCD_ST_IDLE;
          end else begin
            r_next.state = PCD_ST_FILL;
          end
        end
      end
      PCD_ST_FILL: begin
        if (memRspValid) begin
          r_next.rsp.rd = memRsp; // RULE14
          r_next.rsp.lword = r_reg.req.addr[PCD_LW_BIT] ? memRsp.data[PCD_DATA_W-1:PCD_LWORD_W]
                                                        : memRsp.data[PCD_LWORD_W-1:0];
          r_next.rsp.fromCache = 1'b0;
          r_next.rspValid = 1'b1;
          r_next.state = PCD_ST_IDLE;
          // read-lock, i/o space, disabled cache and killed fills never allocate
          fillEn = cacheEnable && !r_reg.killFill && !flushReq && !sameBlockDma
                   && pcd_cacheable(r_reg.req.kind, r_reg.req.addr); // RULE1 RULE2 RULE5 RULE7
          fillBlock = memRsp; // RULE14
        end
      end
    endcase
    if (r_reg.state != PCD_ST_IDLE && (flushReq || sameBlockDma)) begin
      r_next.killFill = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      r_reg <= PCD_CTL_RESET;
    end else begin
      r_reg <= r_next;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign cpuReqReady = r_reg.state == PCD_ST_IDLE;
  assign cpuRspValid = r_reg.rspValid;
  assign cpuRsp = r_reg.rsp;
  assign memReqValid = r_reg.state == PCD_ST_BUS; // RULE3
  assign memReq = r_reg.req;
  assign memRspReady = r_reg.state == PCD_ST_FILL;

endmodule
`default_nettype wire

// ### rtl/pcd_pkg.sv
// shared types and constants of the primary cache
package pcd_pkg;

  // ----------------------------------------------------------------
  // physical address split
  // ----------------------------------------------------------------
  localparam int PCD_PA_HI = 29;
  localparam int PCD_PA_LO = 2;
  localparam int PCD_IO_BIT = 29;
  localparam int PCD_TAG_HI = 28;
  localparam int PCD_TAG_LO = 11;
  localparam int PCD_COL_HI = 10;
  localparam int PCD_COL_LO = 9;
  localparam int PCD_ROW_HI = 8;
  localparam int PCD_ROW_LO = 3;
  localparam int PCD_LW_BIT = 2;
  localparam int PCD_TAG_W = PCD_TAG_HI - PCD_TAG_LO + 1;
  localparam int PCD_ROW_W = PCD_ROW_HI - PCD_ROW_LO + 1;
  localparam int PCD_COL_W = PCD_COL_HI - PCD_COL_LO + 1;

  // ----------------------------------------------------------------
  // geometry
  // ----------------------------------------------------------------
  localparam int PCD_NUM_ROWS = 64;
  localparam int PCD_NUM_COLS = 4;
  localparam int PCD_NUM_BLOCKS = PCD_NUM_ROWS * PCD_NUM_COLS;
  localparam int PCD_BYTES = 8;
  localparam int PCD_DATA_W = 64;
  localparam int PCD_LWORD_W = 32;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef logic [PCD_PA_HI:PCD_PA_LO] pcd_addr_type;

  typedef enum logic [1:0] {PCD_IFETCH, PCD_DREAD, PCD_DREADLOCK, PCD_WRITE} pcd_kind_type;

  typedef struct packed {
    logic [PCD_BYTES-1:0] par;
    logic [PCD_DATA_W-1:0] data;
  } pcd_block_type;

  typedef struct packed {
    pcd_kind_type kind;
    pcd_addr_type addr;
    logic [PCD_BYTES-1:0] mask;
    pcd_block_type wr;
  } pcd_ref_type;

  typedef struct packed {
    pcd_block_type rd;
    logic [PCD_LWORD_W-1:0] lword;
    logic fromCache;
  } pcd_rsp_type;

  typedef struct packed {
    logic par;
    logic [PCD_TAG_W-1:0] tag;
  } pcd_tag_entry_type;

  typedef enum logic [1:0] {PCD_ST_IDLE, PCD_ST_CHECK, PCD_ST_BUS, PCD_ST_FILL} pcd_state_type;

  typedef struct packed {
    pcd_state_type state;
    pcd_ref_type req;
    logic killFill;
    logic rspValid;
    pcd_rsp_type rsp;
  } pcd_ctl_type;

  typedef struct packed {
    logic [PCD_NUM_BLOCKS-1:0] valid;
  } pcd_store_state_type;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam pcd_ctl_type PCD_CTL_RESET = '0;
  localparam pcd_store_state_type PCD_STORE_RESET = '0;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic pcd_cacheable(pcd_kind_type k, pcd_addr_type a);
    return !a[PCD_IO_BIT] && (k == PCD_IFETCH || k == PCD_DREAD);
  endfunction

  function automatic logic pcd_odd_parity(logic [PCD_TAG_W-1:0] t);
    return ~^t;
  endfunction

endpackage

// ### rtl/pcd_tag_store.sv
// tag, valid, tag parity and data arrays of the primary cache
`timescale 1ns/1ns
`default_nettype none
module pcd_tag_store import pcd_pkg::*; #(
  parameter int ROWS = PCD_NUM_ROWS,
  parameter int COLS = PCD_NUM_COLS
) (
  input wire logic clk,
  input wire logic reset,
  input wire pcd_addr_type lookupAddr,
  output logic lookupHit,
  output pcd_block_type lookupBlock,
  input wire pcd_addr_type snoopAddr,
  output logic snoopHit,
  input wire logic fillEn,
  input wire pcd_addr_type fillAddr,
  input wire pcd_block_type fillBlock,
  input wire logic invEn,
  input wire pcd_addr_type invAddr,
  input wire logic flushEn
);

  // the address split fixes the geometry; other sizes cannot be served
  if (ROWS != 2 ** PCD_ROW_W || COLS != 2 ** PCD_COL_W) begin : g_bad_geometry
    $error("pcd_tag_store: ROWS and COLS must match the address split");
  end

  // ----------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------
  pcd_store_state_type s_reg;
  pcd_store_state_type s_next;
  pcd_tag_entry_type tagMem [ROWS][COLS];
  pcd_block_type dataMem [ROWS][COLS];

  function automatic logic [PCD_ROW_W+PCD_COL_W-1:0] blockIndex(pcd_addr_type a);
    return {a[PCD_COL_HI:PCD_COL_LO], a[PCD_ROW_HI:PCD_ROW_LO]};
  endfunction

  function automatic logic entryHit(pcd_addr_type a, pcd_tag_entry_type e, logic v);
    // i/o space addresses share tag bits with memory, so bit 29 gates the match
    return v && !a[PCD_IO_BIT] && e.tag == a[PCD_TAG_HI:PCD_TAG_LO];
  endfunction

  // ----------------------------------------------------------------
  // lookup ports
  // ----------------------------------------------------------------
  always_comb begin
    lookupHit = entryHit(lookupAddr, tagMem[lookupAddr[PCD_ROW_HI:PCD_ROW_LO]][lookupAddr[PCD_COL_HI:PCD_COL_LO]],
                         s_reg.valid[blockIndex(lookupAddr)]); // RULE13
    lookupBlock = dataMem[lookupAddr[PCD_ROW_HI:PCD_ROW_LO]][lookupAddr[PCD_COL_HI:PCD_COL_LO]]; // RULE9
    snoopHit = entryHit(snoopAddr, tagMem[snoopAddr[PCD_ROW_HI:PCD_ROW_LO]][snoopAddr[PCD_COL_HI:PCD_COL_LO]],
                        s_reg.valid[blockIndex(snoopAddr)]);
  end

  // ----------------------------------------------------------------
  // valid bits
  // ----------------------------------------------------------------
  always_comb begin
    s_next = s_reg;
    if (flushEn) begin
      s_next.valid = '0; // RULE12
    end else begin
      if (fillEn) begin
        s_next.valid[blockIndex(fillAddr)] = 1'b1;
      end
      // invalidate wins so a dma write never leaves a stale block behind
      if (invEn) begin
        s_next.valid[blockIndex(invAddr)] = 1'b0; // RULE15
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      s_reg <= PCD_STORE_RESET; // RULE17
    end else begin
      s_reg <= s_next;
    end
  end

  // ----------------------------------------------------------------
  // arrays: no reset, the valid bits guard them
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (fillEn) begin
      tagMem[fillAddr[PCD_ROW_HI:PCD_ROW_LO]][fillAddr[PCD_COL_HI:PCD_COL_LO]] <=
        '{par: pcd_odd_parity(fillAddr[PCD_TAG_HI:PCD_TAG_LO]), tag: fillAddr[PCD_TAG_HI:PCD_TAG_LO]}; // RULE10
      dataMem[fillAddr[PCD_ROW_HI:PCD_ROW_LO]][fillAddr[PCD_COL_HI:PCD_COL_LO]] <= fillBlock; // RULE8
    end
  end

endmodule
`default_nettype wire

// ### verif/pcd_cache_sva.sv
// port assertions of the primary cache
`timescale 1ns/1ns
`default_nettype none
module pcd_cache_sva import pcd_pkg::*; (
  input wire logic clk,
  input wire logic reset,
  input wire logic cpuReqValid,
  input wire logic cpuReqReady,
  input wire pcd_ref_type cpuReq,
  input wire logic cpuRspValid,
  input wire pcd_rsp_type cpuRsp,
  input wire logic memReqValid,
  input wire logic memReqReady,
  input wire pcd_ref_type memReq,
  input wire logic memRspReady,
  input wire logic memRspValid,
  input wire pcd_block_type memRsp
);
  pcd_ref_type reqQ;
  logic [1:0] busN;
  // request now served and bus references made for it
  always_ff @(posedge clk) begin
    if (cpuReqValid && cpuReqReady) begin
      reqQ <= cpuReq;
      busN <= 2'h0;
    end else if (memReqValid && memReqReady) begin
      busN <= busN + 2'h1;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  property p_answer; cpuReqValid && cpuReqReady |=> !cpuReqReady ##[1:30] cpuRspValid; endproperty
  a_answer: assert property (p_answer) else $error("request not answered");
  property p_hit; cpuRspValid && cpuRsp.fromCache |-> busN == 2'h0; endproperty
  a_hit: assert property (p_hit) else $error("hit used the bus");
  property p_one; cpuRspValid && !cpuRsp.fromCache |-> busN == 2'h1; endproperty
  a_one: assert property (p_one) else $error("bus reference count");
  property p_io; cpuRspValid && (reqQ.addr[PCD_IO_BIT] || reqQ.kind[1]) |-> !cpuRsp.fromCache; endproperty
  a_io: assert property (p_io) else $error("io, lock or write hit");
  property p_same; memReqValid |-> memReq.kind == reqQ.kind && memReq.addr == reqQ.addr; endproperty
  a_same: assert property (p_same) else $error("bus reference differs");
  property p_hold; memReqValid && !memReqReady |=> memReqValid && $stable(memReq); endproperty
  a_hold: assert property (p_hold) else $error("bus request dropped");
  property p_fwd; memRspValid && memRspReady |=> cpuRspValid && cpuRsp.rd == $past(memRsp); endproperty
  a_fwd: assert property (p_fwd) else $error("fill not forwarded");
  property p_lw;
    cpuRspValid && reqQ.kind != PCD_WRITE |->
      cpuRsp.lword == (reqQ.addr[PCD_LW_BIT] ? cpuRsp.rd.data[63:32] : cpuRsp.rd.data[31:0]);
  endproperty
  a_lw: assert property (p_lw) else $error("wrong longword");
  c_hit: cover property (cpuRspValid && cpuRsp.fromCache);
  c_fill: cover property (memRspValid && memRspReady);
  c_b2b: cover property (cpuRspValid && cpuReqValid && cpuReqReady);
endmodule
bind pcd_cache pcd_cache_sva u_sva (
  .clk(clk),
  .reset(reset),
  .cpuReqValid(cpuReqValid),
  .cpuReqReady(cpuReqReady),
  .cpuReq(cpuReq),
  .cpuRspValid(cpuRspValid),
  .cpuRsp(cpuRsp),
  .memReqValid(memReqValid),
  .memReqReady(memReqReady),
  .memReq(memReq),
  .memRspReady(memRspReady),
  .memRspValid(memRspValid),
  .memRsp(memRsp)
);
`default_nettype wire

// ### verif/pcd_cache_tb_top.sv
// self-checking bench of the primary cache
`timescale 1ns/1ns
`default_nettype none
module pcd_cache_tb_top import pcd_pkg::*; ;
  logic clk = 1'h0, reset = 1'h1, cpuReqValid = 1'h0, cacheEnable = 1'h1;
  logic flushReq = 1'h0, dmaWrValid = 1'h0, slow = 1'h0;
  logic cpuReqReady, cpuRspValid, memReqValid, memReqReady, memRspReady, memRspValid;
  pcd_ref_type cpuReq = '0, memReq;
  pcd_rsp_type cpuRsp;
  pcd_addr_type dmaWrAddr = '0, base = 28'h0000128, a2, ra;
  pcd_block_type memRsp, mem [logic [26:0]];
  logic [17:0] tagM [256];
  logic [255:0] vld = '0;
  int error_cnt = 0, n_compared = 0, busN = 0, n, bits[6] = '{2, 3, 9, 10, 11, 28};
  pcd_cache u_dut (
    .clk(clk),
    .reset(reset),
    .cpuReqValid(cpuReqValid),
    .cpuReqReady(cpuReqReady),
    .cpuReq(cpuReq),
    .cpuRspValid(cpuRspValid),
    .cpuRsp(cpuRsp),
    .cacheEnable(cacheEnable),
    .flushReq(flushReq),
    .dmaWrValid(dmaWrValid),
    .dmaWrAddr(dmaWrAddr),
    .memReqValid(memReqValid),
    .memReqReady(memReqReady),
    .memReq(memReq),
    .memRspReady(memRspReady),
    .memRspValid(memRspValid),
    .memRsp(memRsp)
  );
  pcd_mem_model u_mem (
    .clk(clk),
    .reset(reset),
    .slow(slow),
    .memReqValid(memReqValid),
    .memReqReady(memReqReady),
    .memReq(memReq),
    .memRspReady(memRspReady),
    .memRspValid(memRspValid),
    .memRsp(memRsp)
  );
  always #5 clk = ~clk;
  always @(posedge clk) if (memReqValid && memReqReady) busN++;
  task automatic cmp(string what, logic [71:0] exp, logic [71:0] got);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic results();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // memory content of a quadword: what was written, else a pattern made from its address
  function automatic pcd_block_type expBlock(pcd_addr_type a);
    return mem.exists(a[29:3]) ? mem[a[29:3]] : {a[10:3], {2{4'h0, a[29:3], 1'h1}}};
  endfunction
  task automatic doRef(pcd_kind_type k, pcd_addr_type a, logic [7:0] m, pcd_block_type w);
    logic cach, hitE;
    int b0, i;
    pcd_block_type e;
    cach = !a[29] && (k == PCD_IFETCH || k == PCD_DREAD) && cacheEnable;
    hitE = cach && vld[a[10:3]] && tagM[a[10:3]] === a[28:11];
    b0 = busN;
    cpuReq = '{k, a, m, w};
    cpuReqValid = 1'h1;
    for (i = 0; i < 50 && cpuReqReady !== 1'h1; i++) @(negedge clk);
    if (i == 50) begin
      error_cnt++;
      results();
    end
    @(negedge clk);
    cpuReqValid = 1'h0;
    for (i = 0; i < 50 && cpuRspValid !== 1'h1; i++) @(negedge clk);
    if (i == 50) begin
      error_cnt++;
      results();
    end
    e = expBlock(a);
    cmp("fromCache", hitE, cpuRsp.fromCache);
    cmp("busRefs", !hitE, busN - b0);
    if (k == PCD_WRITE) begin
      for (i = 0; i < 8; i++) if (m[i]) {e.par[i], e.data[8*i+:8]} = {w.par[i], w.data[8*i+:8]};
      mem[a[29:3]] = e;
    end else begin
      cmp("block", e, cpuRsp.rd);
      cmp("lword", a[2] ? e.data[63:32] : e.data[31:0], cpuRsp.lword);
    end
    if (cach) begin
      vld[a[10:3]] = 1'h1;
      tagM[a[10:3]] = a[28:11];
    end
  endtask
  task automatic rd(pcd_kind_type k, pcd_addr_type a);
    doRef(k, a, 8'h00, '0);
  endtask
  task automatic dma(pcd_addr_type a);
    dmaWrAddr = a;
    dmaWrValid = 1'h1;
    @(negedge clk);
    dmaWrValid = 1'h0;
    if (!a[29] && tagM[a[10:3]] === a[28:11]) vld[a[10:3]] = 1'h0;
  endtask
  task automatic flush();
    flushReq = 1'h1;
    @(negedge clk);
    flushReq = 1'h0;
    vld = '0;
  endtask
  task automatic doReset(int c);
    reset = 1'h1;
    repeat (c) @(negedge clk);
    cmp("resetOut", 4'h8, {cpuReqReady, cpuRspValid, memReqValid, memRspReady});
    reset = 1'h0;
    vld = '0;
  endtask
  initial begin
    void'($urandom(65367));
    doReset(20);
    for (n = 0; n < 6; n++) begin
      a2 = base;
      a2[5:3] = 3'(n);
      a2[29] = n[0];
      repeat (2) rd(pcd_kind_type'(n / 2), a2);
    end
    $display("kinds done");
    foreach (bits[i]) begin
      a2 = base;
      a2[bits[i]] = ~a2[bits[i]];
      rd(PCD_IFETCH, a2);
      rd(PCD_DREAD, base);
    end
    $display("geometry done");
    a2[20] = 1'h1;
    doRef(PCD_WRITE, a2, 8'h3C, 72'h5A0123456789ABCDEF);
    repeat (2) rd(PCD_DREAD, a2);
    doRef(PCD_WRITE, a2, 8'hC3, 72'hA5FEDCBA9876543210);
    rd(PCD_DREAD, a2);
    $display("writes done");
    dma(a2);
    repeat (2) rd(PCD_DREAD, a2);
    flush();
    rd(PCD_DREAD, a2);
    cacheEnable = 1'h0;
    repeat (2) rd(PCD_DREAD, a2);
    cacheEnable = 1'h1;
    doReset(3);
    // a dma write or a flush while the miss is on the bus forwards the data but must not allocate
    fork
      rd(PCD_DREAD, a2);
      begin repeat (2) @(negedge clk); dma(a2); end
    join
    vld = '0;
    fork
      rd(PCD_DREAD, a2);
      begin repeat (2) @(negedge clk); flush(); end
    join
    vld = '0;
    rd(PCD_DREAD, a2);
    $display("control done");
    for (n = 0; n < 400; n++) begin
      // few tags and indexes so that hits, evictions and snoop hits are common
      ra = {1'($urandom_range(0, 7) == 0), 17'h0, 1'($urandom), 2'($urandom), 3'h0, 3'($urandom), 1'($urandom)};
      slow = 1'($urandom);
      case ($urandom_range(0, 9))
        0: dma(ra);
        1: flush();
        2: cacheEnable = $urandom_range(0, 3) != 0;
        default: ;
      endcase
      doRef(pcd_kind_type'(2'($urandom)), ra, 8'($urandom), 72'({$urandom, $urandom, $urandom}));
    end
    $display("random done");
    results();
  end
endmodule
`default_nettype wire

// ### verif/pcd_mem_model.sv
// memory on the far side of the cpu memory bus
`timescale 1ns/1ns
`default_nettype none
module pcd_mem_model import pcd_pkg::*; (
  input wire logic clk,
  input wire logic reset,
  input wire logic slow,
  input wire logic memReqValid,
  output logic memReqReady,
  input wire pcd_ref_type memReq,
  input wire logic memRspReady,
  output logic memRspValid,
  output pcd_block_type memRsp
);
  pcd_block_type mem [logic [26:0]];
  pcd_block_type b, rb;
  logic pend = 1'h0;
  int wt = 0;
  initial memReqReady = 1'h0;
  initial memRspValid = 1'h0;
  initial memRsp = '0;
  always @(posedge clk) begin
    memReqReady <= 1'h0;
    memRspValid <= 1'h0;
    memRsp <= ~memRsp; // released lines keep changing
    if (reset) begin
      pend <= 1'h0;
      wt <= 0;
    end else if (wt > 0) begin
      wt <= wt - 1;
    end else if (memReqValid && memReqReady) begin
      // look up only when a reference is taken, so an idle bus never indexes with unknowns
      b = mem.exists(memReq.addr[29:3]) ? mem[memReq.addr[29:3]] :
        {memReq.addr[10:3], {2{4'h0, memReq.addr[29:3], 1'h1}}};
      wt <= slow ? 3 : 0;
      if (memReq.kind == PCD_WRITE) begin
        for (int i = 0; i < 8; i++)
          if (memReq.mask[i]) {b.par[i], b.data[8*i+:8]} = {memReq.wr.par[i], memReq.wr.data[8*i+:8]};
        mem[memReq.addr[29:3]] = b;
      end else begin
        pend <= 1'h1;
        rb <= b;
      end
    end else if (memReqValid) begin
      memReqReady <= 1'h1;
    end else if (pend && memRspReady) begin
      pend <= 1'h0;
      memRspValid <= 1'h1;
      memRsp <= rb;
    end
  end
endmodule
`default_nettype wire
